// ==== frta_pkg.sv ====
// constants and carrier types for the packet ram test access path
package frta_pkg;

  localparam int          RAM_DEPTH  = 2560;
  localparam int          RAM_WIDTH  = 33;
  localparam int          DATA_WIDTH = 32;
  localparam int          ADDR_WIDTH = 12;
  localparam logic [7:0]  TEST_ADDR  = 8'hC0;
  localparam logic [11:0] CTR_RESET  = 12'h000;
  localparam logic [11:0] LAST_LOC   = 12'h9FF;

  typedef enum logic {
    FRTA_NORMAL = 1'b0,
    FRTA_TEST   = 1'b1
  } frta_mode_t;

  // one host bus access as seen by this block
  typedef struct packed {
    logic                  rd;
    logic                  wr;
    logic [7:0]            addr;
    logic [DATA_WIDTH-1:0] data;
  } frta_host_req_t;

  // one access from the normal fifo logic
  typedef struct packed {
    logic                  rd;
    logic                  wr;
    logic [ADDR_WIDTH-1:0] addr;
    logic [RAM_WIDTH-1:0]  data;
  } frta_fifo_req_t;

endpackage : frta_pkg

// ==== frta_ram.sv ====
// packet ram: flip-flop storage with one write port and two read ports
`timescale 1ns/1ps
module frta_ram
  import frta_pkg::*;
#(
  parameter int DEPTH = RAM_DEPTH,
  parameter int WIDTH = RAM_WIDTH,
  parameter int AW    = ADDR_WIDTH
) (
  input  wire logic             mclk,
  input  wire logic             rst,
  input  wire logic             wrEn,
  input  wire logic [AW-1:0]    wrAddr,
  input  wire logic [WIDTH-1:0] wrData,
  input  wire logic [AW-1:0]    rdAddrA,
  output logic      [WIDTH-1:0] rdDataA,
  input  wire logic [AW-1:0]    rdAddrB,
  output logic      [WIDTH-1:0] rdDataB
);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
  } frta_ram_state_t;

  frta_ram_state_t st;
  frta_ram_state_t next_st;

  // reads are plain muxes on the flops; out of range indices read zero
  always_comb begin
    rdDataA = (int'(rdAddrA) < DEPTH) ? st.mem[rdAddrA] : '0;
    rdDataB = (int'(rdAddrB) < DEPTH) ? st.mem[rdAddrB] : '0;
  end

  always_comb begin
    next_st = st;
    if (wrEn && int'(wrAddr) < DEPTH) begin
      next_st.mem[wrAddr] = wrData;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

endmodule : frta_ram

// ==== frta_test_access.sv ====
// ram test access path to the shared packet ram, with normal fifo port gating
`timescale 1ns/1ps
module frta_test_access
  import frta_pkg::*;
#(
  parameter int ATF_SIZE = 1024,
  parameter int ITF_SIZE = 512
) (
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // control and status bits
  input  wire logic                  ramTestEnable,
  input  wire logic                  addressClear,
  input  wire logic                  controlBitSource,
  input  wire logic                  counterLoad,
  input  wire logic [ADDR_WIDTH-1:0] counterLoadValue,
  output logic      [ADDR_WIDTH-1:0] ramAddressCounter,
  output logic                       controlCompareError,
  output logic                       controlBitValue,
  output logic                       controlBitFlag,
  output logic                       testModeActive,
  output logic                       fifoFreeze,
  // host bus access
  input  wire frta_host_req_t        hostReq,
  output logic      [DATA_WIDTH-1:0] hostRdData,
  output logic                       hostRdValid,
  // normal fifo logic access
  input  wire frta_fifo_req_t        fifoReq,
  output logic      [RAM_WIDTH-1:0]  fifoRdData,
  output logic                       fifoRdValid,
  // fifo partition bases
  output logic      [ADDR_WIDTH-1:0] atfBase,
  output logic      [ADDR_WIDTH-1:0] itfBase,
  output logic      [ADDR_WIDTH-1:0] grfBase
);

  typedef struct packed {
    frta_mode_t            mode;
    logic [ADDR_WIDTH-1:0] ctr;
    logic                  err;
    logic                  bitValue;
    logic                  flag;
    logic [DATA_WIDTH-1:0] rdData;
    logic                  rdValid;
    logic [RAM_WIDTH-1:0]  fifoRdData;
    logic                  fifoRdValid;
    logic [ADDR_WIDTH-1:0] atfBase;
    logic [ADDR_WIDTH-1:0] itfBase;
    logic [ADDR_WIDTH-1:0] grfBase;
  } frta_state_t;

  localparam logic [ADDR_WIDTH-1:0] ATF_START = CTR_RESET;
  localparam logic [ADDR_WIDTH-1:0] ITF_START = ADDR_WIDTH'(ATF_SIZE);
  localparam logic [ADDR_WIDTH-1:0] GRF_START = ADDR_WIDTH'(ATF_SIZE + ITF_SIZE);

  frta_state_t st;
  frta_state_t next_st;

  logic                  testWr;
  logic                  testRd;
  logic                  ramWrEn;
  logic [ADDR_WIDTH-1:0] ramWrAddr;
  logic [RAM_WIDTH-1:0]  ramWrData;
  logic [ADDR_WIDTH-1:0] ramRdAddrA;
  logic [RAM_WIDTH-1:0]  ramRdDataA;
  logic [RAM_WIDTH-1:0]  ramRdDataB;
  logic [ADDR_WIDTH-1:0] flagAddr;
  logic                  readMismatch;

  // next counter value; the last location wraps back to zero
  function automatic logic [ADDR_WIDTH-1:0] step_addr(input logic [ADDR_WIDTH-1:0] a);
    step_addr = (a == LAST_LOC) ? CTR_RESET : a + 12'h001;
  endfunction : step_addr

  // a host access belongs to the test path only in test mode and at the test address
  function automatic logic test_hit(
    input frta_mode_t mode,
    input logic [7:0] addr
  );
    test_hit = (mode == FRTA_TEST) && (addr == TEST_ADDR);
  endfunction : test_hit

  // stored control bit against the one the host expects
  function automatic logic ctrl_mismatch(
    input logic [RAM_WIDTH-1:0] word,
    input logic                 src
  );
    ctrl_mismatch = word[RAM_WIDTH-1] != src;
  endfunction : ctrl_mismatch

  // clear ranks above load, load above the access step
  function automatic logic [ADDR_WIDTH-1:0] next_ctr(
    input logic [ADDR_WIDTH-1:0] ctr,
    input logic                  clr,
    input logic                  load,
    input logic [ADDR_WIDTH-1:0] loadValue,
    input logic                  stepEn
  );
    if (clr) begin
      next_ctr = CTR_RESET;
    end else if (load) begin
      next_ctr = loadValue;
    end else if (stepEn) begin
      next_ctr = step_addr(ctr);
    end else begin
      next_ctr = ctr;
    end
  endfunction : next_ctr

  // set wins over clear, so a mismatch in the clearing cycle is not lost
  function automatic logic next_err(
    input logic err,
    input logic clr,
    input logic setEvent
  );
    if (setEvent) begin
      next_err = 1'b1;
    end else if (clr) begin
      next_err = 1'b0;
    end else begin
      next_err = err;
    end
  endfunction : next_err

  // a write landing on the word the flag will show is forwarded, else the
  // flag would lag one access behind the ram
  function automatic logic flag_bit(
    input logic [RAM_WIDTH-1:0]  word,
    input logic                  wrEn,
    input logic [ADDR_WIDTH-1:0] wrAddr,
    input logic [RAM_WIDTH-1:0]  wrData,
    input logic [ADDR_WIDTH-1:0] addr
  );
    if (wrEn && wrAddr == addr) begin
      flag_bit = wrData[RAM_WIDTH-1];
    end else begin
      flag_bit = word[RAM_WIDTH-1];
    end
  endfunction : flag_bit

  // only accesses to the test address count while test mode is active
  always_comb begin
    testWr       = test_hit(st.mode, hostReq.addr) && hostReq.wr;
    testRd       = test_hit(st.mode, hostReq.addr) && hostReq.rd && !hostReq.wr;
    readMismatch = testRd && ctrl_mismatch(ramRdDataA, controlBitSource);
  end

  // ram port steering: the test path owns the ram while in test mode
  always_comb begin
    if (st.mode == FRTA_TEST) begin
      ramWrEn    = testWr;
      ramWrAddr  = st.ctr;
      ramWrData  = {controlBitSource, hostReq.data};
      ramRdAddrA = st.ctr;
    end else begin
      ramWrEn    = fifoReq.wr;
      ramWrAddr  = fifoReq.addr;
      ramWrData  = fifoReq.data;
      ramRdAddrA = fifoReq.addr;
    end
  end

  frta_ram #(
    .DEPTH (RAM_DEPTH),
    .WIDTH (RAM_WIDTH),
    .AW    (ADDR_WIDTH)
  ) u_ram (
    .mclk    (mclk),
    .rst     (rst),
    .wrEn    (ramWrEn),
    .wrAddr  (ramWrAddr),
    .wrData  (ramWrData),
    .rdAddrA (ramRdAddrA),
    .rdDataA (ramRdDataA),
    .rdAddrB (flagAddr),
    .rdDataB (ramRdDataB)
  );

  always_comb begin
    next_st = st;
    flagAddr = CTR_RESET;

    next_st.mode = ramTestEnable ? FRTA_TEST : FRTA_NORMAL;
    next_st.rdValid = 1'b0;
    next_st.fifoRdValid = 1'b0;

    // partition bases are fixed by the fifo sizes
    next_st.atfBase = ATF_START;
    next_st.itfBase = ITF_START;
    next_st.grfBase = GRF_START;

    if (st.mode == FRTA_TEST) begin
      // read data comes straight from the flops, so no wait state is needed
      if (testRd) begin
        next_st.rdData  = ramRdDataA[DATA_WIDTH-1:0];
        next_st.rdValid = 1'b1;
      end

      next_st.ctr = next_ctr(st.ctr, addressClear, counterLoad, counterLoadValue,
                             testWr || testRd);
      next_st.err = next_err(st.err, addressClear, readMismatch);

      // flag tracks the word the counter will point at next cycle
      flagAddr     = next_st.ctr;
      next_st.flag = flag_bit(ramRdDataB, ramWrEn, ramWrAddr, ramWrData, flagAddr);
    end else begin
      // counter loads and clears still land outside test mode; nothing steps
      next_st.ctr  = next_ctr(st.ctr, addressClear, counterLoad, counterLoadValue, 1'b0);
      next_st.err  = next_err(st.err, addressClear, 1'b0);
      flagAddr     = next_st.ctr;
      next_st.flag = 1'b0;
      // normal fifo reads only run while test mode is off
      if (fifoReq.rd) begin
        next_st.fifoRdData  = ramRdDataA;
        next_st.fifoRdValid = 1'b1;
      end
    end

    next_st.bitValue = next_st.err ^ controlBitSource;
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '{mode: FRTA_NORMAL, ctr: CTR_RESET, default: '0};
    end else begin
      st <= next_st;
    end
  end

  always_comb begin
    ramAddressCounter   = st.ctr;
    controlCompareError = st.err;
    controlBitValue     = st.bitValue;
    controlBitFlag      = st.flag;
    testModeActive      = st.mode == FRTA_TEST;
    fifoFreeze          = st.mode == FRTA_TEST;
    hostRdData          = st.rdData;
    hostRdValid         = st.rdValid;
    fifoRdData          = st.fifoRdData;
    fifoRdValid         = st.fifoRdValid;
    atfBase             = st.atfBase;
    itfBase             = st.itfBase;
    grfBase             = st.grfBase;
  end

endmodule : frta_test_access

// ==== frta_checker.sv ====
// assertions on the test access ports
`timescale 1ns/1ps
module frta_checker
  import frta_pkg::*;
(
  input wire logic                  mclk,
  input wire logic                  rst,
  input wire logic                  ramTestEnable,
  input wire logic                  addressClear,
  input wire logic                  controlBitSource,
  input wire logic                  counterLoad,
  input wire logic [ADDR_WIDTH-1:0] counterLoadValue,
  input wire logic [ADDR_WIDTH-1:0] ramAddressCounter,
  input wire logic                  controlCompareError,
  input wire logic                  controlBitValue,
  input wire logic                  testModeActive,
  input wire logic                  fifoFreeze,
  input wire frta_host_req_t        hostReq,
  input wire logic                  hostRdValid,
  input wire frta_fifo_req_t        fifoReq,
  input wire logic                  fifoRdValid
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take;
    testModeActive && (hostReq.rd || hostReq.wr) && hostReq.addr == TEST_ADDR;
  endsequence
  sequence s_step;
    s_take ##0 (!addressClear && !counterLoad);
  endsequence
  chk_read_answer: assert property (s_take ##0 !hostReq.wr |=> hostRdValid)
    else $error("read not answered");
  chk_count_step: assert property (s_step |=> ramAddressCounter ==
    (($past(ramAddressCounter) == LAST_LOC) ? CTR_RESET : $past(ramAddressCounter) + 12'h001))
    else $error("counter step wrong");
  chk_clear_zero: assert property (addressClear |=> ramAddressCounter == CTR_RESET)
    else $error("counter not cleared");
  chk_load_value: assert property (counterLoad && !addressClear |=>
    ramAddressCounter == $past(counterLoadValue))
    else $error("counter not loaded");
  chk_error_sticky: assert property (controlCompareError && !addressClear |=> controlCompareError)
    else $error("error flag dropped");
  chk_bit_value: assert property (1'b1 |=>
    controlBitValue == (controlCompareError ^ $past(controlBitSource)))
    else $error("control bit value wrong");
  chk_mode_follow: assert property (1'b1 |=>
    testModeActive == $past(ramTestEnable) && fifoFreeze == testModeActive)
    else $error("mode not following enable");
  chk_fifo_blocked: assert property (fifoFreeze && fifoReq.rd |=> !fifoRdValid)
    else $error("fifo read in test mode");
endmodule : frta_checker

bind frta_test_access frta_checker chk (.*);

// ==== frta_host_model.sv ====
// host processor model: control bits and host bus accesses
`timescale 1ns/1ps
module frta_host_model
  import frta_pkg::*;
(
  input  wire logic            mclk,
  output frta_host_req_t       hostReq,
  output logic                 ramTestEnable,
  output logic                 addressClear,
  output logic                 controlBitSource,
  output logic                 counterLoad,
  output logic [ADDR_WIDTH-1:0] counterLoadValue
);
  initial begin
    hostReq = '{1'b0, 1'b0, TEST_ADDR, 32'hFFFF_FFFF};
    {ramTestEnable, addressClear, controlBitSource, counterLoad} = 4'h0;
    counterLoadValue = 12'h000;
  end
  task automatic acc(input logic w, r, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    hostReq <= '{r, w, a, d};
  endtask : acc
  // released data flips so a stale word never looks fresh
  task automatic idle;
    @(posedge mclk);
    hostReq <= '{1'b0, 1'b0, TEST_ADDR, ~hostReq.data};
  endtask : idle
  task automatic ctl(input logic en, src);
    @(posedge mclk);
    ramTestEnable <= en;
    controlBitSource <= src;
  endtask : ctl
  task automatic clr;
    @(posedge mclk);
    addressClear <= 1'b1;
    @(posedge mclk);
    addressClear <= 1'b0;
  endtask : clr
  task automatic load(input logic [ADDR_WIDTH-1:0] v);
    @(posedge mclk);
    counterLoadValue <= v;
    counterLoad <= 1'b1;
    @(posedge mclk);
    counterLoad <= 1'b0;
  endtask : load
endmodule : frta_host_model

// ==== frta_test_access_bench.sv ====
// self-checking bench for the test access path
`timescale 1ns/1ps
module frta_test_access_bench
  import frta_pkg::*;
;
  logic mclk, rst, ramTestEnable, addressClear, controlBitSource, counterLoad;
  logic [ADDR_WIDTH-1:0] counterLoadValue, ramAddressCounter, atfBase, itfBase, grfBase;
  logic controlCompareError, controlBitValue, controlBitFlag, testModeActive, fifoFreeze;
  logic hostRdValid, fifoRdValid;
  logic [DATA_WIDTH-1:0] hostRdData;
  logic [RAM_WIDTH-1:0] fifoRdData;
  frta_host_req_t hostReq;
  frta_fifo_req_t fifoReq;
  int nErrors = 0;
  int cmpCount = 0;
  frta_test_access dut (.*);
  frta_host_model host (.*);
  task automatic chk(input string n, input logic [33:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      nErrors++;
      $display("unexpected %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic rdChk(input logic [31:0] d, input logic err);
    host.acc(1'b0, 1'b1, TEST_ADDR, 32'h0000_0000);
    host.idle();
    #1;
    chk("read", {hostRdValid, hostRdData}, {1'b1, d});
    chk("error", controlCompareError, err);
  endtask : rdChk
  task automatic testAccess;
    host.acc(1'b1, 1'b0, TEST_ADDR, 32'h1111_1111);
    host.idle();
    host.ctl(1'b1, 1'b1);
    @(posedge mclk);
    #1;
    chk("mode", {testModeActive, fifoFreeze, ramAddressCounter}, 14'h3000);
    chk("atf base", atfBase, 12'h000);
    chk("itf base", itfBase, 12'h400);
    chk("grf base", grfBase, 12'h600);
    host.clr();
    host.acc(1'b1, 1'b0, TEST_ADDR, 32'hA5A5_0000);
    host.acc(1'b1, 1'b0, TEST_ADDR, 32'hA5A5_0001);
    host.idle();
    host.ctl(1'b1, 1'b0);
    host.acc(1'b1, 1'b0, TEST_ADDR, 32'hA5A5_0002);
    host.acc(1'b1, 1'b0, 8'hC4, 32'h0000_0000);
    host.idle();
    #1;
    chk("counter", ramAddressCounter, 12'h003);
    host.clr();
    #1;
    chk("flag", controlBitFlag, 1'b1);
    host.ctl(1'b1, 1'b1);
    rdChk(32'hA5A5_0000, 1'b0);
    rdChk(32'hA5A5_0001, 1'b0);
    rdChk(32'hA5A5_0002, 1'b1);
    @(posedge mclk);
    #1;
    chk("bit value", controlBitValue, 1'b0);
    $display("access test done");
  endtask : testAccess
  task automatic testWrap;
    host.ctl(1'b1, 1'b0);
    host.load(LAST_LOC);
    host.acc(1'b1, 1'b0, TEST_ADDR, 32'h5A5A_09FF);
    host.idle();
    #1;
    chk("wrap", ramAddressCounter, CTR_RESET);
    host.load(LAST_LOC);
    rdChk(32'h5A5A_09FF, 1'b1);
    host.clr();
    #1;
    chk("clear", {controlCompareError, ramAddressCounter}, 13'h0000);
    $display("wrap test done");
  endtask : testWrap
  task automatic testFifo;
    @(posedge mclk);
    fifoReq <= '{1'b1, 1'b1, 12'h001, 33'h0_0000_0000};
    host.ctl(1'b0, 1'b0);
    #1;
    chk("frozen", fifoRdValid, 1'b0);
    @(posedge mclk);
    fifoReq <= '{1'b1, 1'b0, 12'h001, 33'h0_0000_0000};
    #1;
    chk("frozen late", fifoRdValid, 1'b0);
    @(posedge mclk);
    fifoReq <= '0;
    #1;
    chk("fifo read", {fifoRdValid, fifoRdData}, {2'b11, 32'hA5A5_0001});
    @(posedge mclk);
    fifoReq <= '{1'b0, 1'b1, 12'h005, 33'h1_0000_0005};
    @(posedge mclk);
    fifoReq <= '{1'b1, 1'b0, 12'h005, 33'h0_0000_0000};
    @(posedge mclk);
    fifoReq <= '0;
    #1;
    chk("fifo write", {fifoRdValid, fifoRdData}, {1'b1, 33'h1_0000_0005});
    $display("fifo test done");
  endtask : testFifo
  task automatic tallyAndFinish;
    $display("compares %0d mismatches %0d", cmpCount, nErrors);
    if (nErrors == 0 && cmpCount > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : tallyAndFinish
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // the tests need well under a thousand cycles
  initial begin
    #20000;
    nErrors++;
    tallyAndFinish();
  end
  initial begin
    rst = 1'b1;
    fifoReq = '0;
    repeat (10) @(posedge mclk);
    rst <= 1'b0;
    testAccess();
    testWrap();
    testFifo();
    tallyAndFinish();
  end
endmodule : frta_test_access_bench
